// >>> design/ncif_pkg.sv
`default_nettype none
package ncif_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 8;
  // coprocessor/cpu reset pulse length in ns
  localparam int unsigned RESET_PULSE_NS    = 200;
  // least time, so round up
  localparam int unsigned RESET_PULSE_CYC   =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_CNT_W       = 8;
  localparam logic [RESET_CNT_W-1:0] RESET_LOAD = RESET_PULSE_CYC[RESET_CNT_W-1:0];
  localparam logic [RESET_CNT_W-1:0] RESET_CNT_INIT = 8'h00;

  localparam int unsigned IO_ADDR_W         = 16;
  localparam logic [IO_ADDR_W-1:0] PORT_COPRO_RESET = 16'h00F1;

  // position of the disable bit inside the misc setup register
  localparam int unsigned PORT_RESET_DISABLE_BIT = 6;

  localparam int unsigned SYNC_STAGES       = 2;
  localparam int unsigned COPRO_PIN_W       = 3;

  typedef struct packed {
    logic busyN;
    logic errorN;
    logic xferReq;
  } ncif_copro_pins_t;

  localparam ncif_copro_pins_t COPRO_PINS_IDLE = '{busyN: 1'b1, errorN: 1'b1, xferReq: 1'b0};

endpackage
`default_nettype wire

// >>> design/ncif_sync.sv
`default_nettype none
module ncif_sync
  import ncif_pkg::*;
#(
  parameter int unsigned         WIDTH = COPRO_PIN_W,
  parameter logic [WIDTH-1:0]    INIT  = '0
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [WIDTH-1:0]  asyncIn,
  output logic      [WIDTH-1:0]  syncOut
);

  // one two-flop chain per bit; the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [SYNC_STAGES-1:0] chain_reg;
      always_ff @(posedge core_clk) begin
        if (rst) begin
          chain_reg <= {SYNC_STAGES{INIT[i]}};
        end else begin
          chain_reg <= {chain_reg[SYNC_STAGES-2:0], asyncIn[i]};
        end
      end
      assign syncOut[i] = chain_reg[SYNC_STAGES-1];
    end
  endgenerate

endmodule
`default_nettype wire

// >>> design/ncif_core.sv
// Overview of operation
// - The active-low busy input is decoded only to qualify the error interrupt; the cpu request path does not decode it.
// - The active-low error input is gated with busy and latched to form the error interrupt.
// - The coprocessor transfer request passes to the cpu, but is gated off while an error is latched.
// - A system reset request asserts both the coprocessor reset and the cpu reset outputs.
// - A write to the coprocessor reset port pulses the coprocessor reset only, never the cpu reset.
// - While the port reset disable bit is set, writes to that port produce no coprocessor reset.
`default_nettype none
module ncif_core
  import ncif_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire ncif_copro_pins_t      coproPins,
  input  wire logic                  sysResetReq,
  input  wire logic                  ioWrStb,
  input  wire logic [IO_ADDR_W-1:0]  ioAddr,
  input  wire logic                  portResetDisable,
  output logic                       coproErrorIrq,
  output logic                       cpuXferReq,
  output logic                       coproResetOut,
  output logic                       cpuResetOut
);

  ncif_copro_pins_t               pinSync;
  logic                           portHit;
  logic                           portReset;
  logic                           errSet;
  logic                           errClear;
  logic                           errLatch_reg;
  logic [RESET_CNT_W-1:0]         resetCnt_reg;
  logic [RESET_CNT_W-1:0]         resetCnt_next;
  logic                           coproRst_reg;
  logic                           cpuRst_reg;

  function automatic logic portDecode(input logic stb, input logic [IO_ADDR_W-1:0] addr);
    portDecode = stb && (addr == PORT_COPRO_RESET);
  endfunction

  // pins come from the coprocessor clock domain, so they are synchronised first
  ncif_sync #(
    .WIDTH (COPRO_PIN_W),
    .INIT  (COPRO_PINS_IDLE)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (coproPins),
    .syncOut  (pinSync)
  );

  assign portHit   = portDecode(ioWrStb, ioAddr);
  // a disabled port write is dropped here, before it can load the counter
  assign portReset = portHit && !portResetDisable;

  // error only counts while the coprocessor still reports busy
  assign errSet   = !pinSync.errorN && !pinSync.busyN;
  assign errClear = sysResetReq || portReset;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      errLatch_reg <= 1'b0;
    end else if (errSet) begin
      // set wins over a clear in the same cycle, so no error is lost
      errLatch_reg <= 1'b1;
    end else if (errClear) begin
      errLatch_reg <= 1'b0;
    end
  end

  assign coproErrorIrq = errLatch_reg;

  // at-style gating: no operand transfers reach the cpu while an error is pending
  assign cpuXferReq = pinSync.xferReq && !errLatch_reg;

  always_comb begin
    resetCnt_next = resetCnt_reg;
    if (sysResetReq) begin
      resetCnt_next = RESET_LOAD;
    end else if (portReset && resetCnt_reg == RESET_CNT_INIT) begin
      // a port write during a running pulse is absorbed, not stretched
      resetCnt_next = RESET_LOAD;
    end else if (resetCnt_reg != RESET_CNT_INIT) begin
      resetCnt_next = resetCnt_reg - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resetCnt_reg <= RESET_CNT_INIT;
    end else begin
      resetCnt_reg <= resetCnt_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      coproRst_reg <= 1'b0;
    end else begin
      coproRst_reg <= (resetCnt_next != RESET_CNT_INIT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpuRst_reg <= 1'b0;
    end else if (sysResetReq) begin
      cpuRst_reg <= 1'b1;
    // cpu reset shares the coprocessor counter, so both pulses end on the same edge
    end else if (resetCnt_next == RESET_CNT_INIT) begin
      cpuRst_reg <= 1'b0;
    end
  end

  assign coproResetOut = coproRst_reg;
  assign cpuResetOut   = cpuRst_reg;

  a_error_sets_latch: assert property (@(posedge core_clk) disable iff (rst)
    (!pinSync.errorN && !pinSync.busyN) |=> coproErrorIrq)
    else $error("error with busy did not raise the interrupt");

  a_error_needs_busy: assert property (@(posedge core_clk) disable iff (rst)
    (!coproErrorIrq && (pinSync.busyN || pinSync.errorN)) |=> !coproErrorIrq)
    else $error("interrupt raised without error and busy");

  a_latch_holds_irq: assert property (@(posedge core_clk) disable iff (rst)
    (coproErrorIrq && !sysResetReq && !portReset) |=> coproErrorIrq)
    else $error("latched error dropped without a reset");

  a_latch_clears_irq: assert property (@(posedge core_clk) disable iff (rst)
    (coproErrorIrq && sysResetReq && (pinSync.busyN || pinSync.errorN)) |=> !coproErrorIrq)
    else $error("system reset did not clear latched error");

  a_xfer_gated_off: assert property (@(posedge core_clk) disable iff (rst)
    cpuXferReq |-> (pinSync.xferReq && !coproErrorIrq))
    else $error("cpu request passed during error");

  a_xfer_passes_through: assert property (@(posedge core_clk) disable iff (rst)
    (!coproErrorIrq && pinSync.xferReq) |-> cpuXferReq)
    else $error("cpu request not forwarded");

  a_sys_resets_both: assert property (@(posedge core_clk) disable iff (rst)
    sysResetReq |=> (coproResetOut && cpuResetOut) [*8])
    else $error("system reset did not assert both reset outputs");

  a_port_copro_only: assert property (@(posedge core_clk) disable iff (rst)
    (portReset && !coproResetOut && !sysResetReq) |=> coproResetOut && !cpuResetOut)
    else $error("port write did not reset coprocessor alone");

  a_port_pulse_width: assert property (@(posedge core_clk) disable iff (rst)
    (portReset && !coproResetOut && !sysResetReq) |=> coproResetOut ##25 !coproResetOut)
    else $error("port reset pulse has wrong length");

  a_disable_blocks_port: assert property (@(posedge core_clk) disable iff (rst)
    (portHit && portResetDisable && !sysResetReq && !coproResetOut) |=> !coproResetOut)
    else $error("disabled port write reset the coprocessor");

  a_port_clears_irq: assert property (@(posedge core_clk) disable iff (rst)
    (coproErrorIrq && portReset && !errSet) |=> !coproErrorIrq)
    else $error("accepted port write did not clear latched error");

  a_disable_keeps_irq: assert property (@(posedge core_clk) disable iff (rst)
    (coproErrorIrq && portHit && portResetDisable && !sysResetReq) |=> coproErrorIrq)
    else $error("disabled port write cleared latched error");

  a_irq_fall_cause: assert property (@(posedge core_clk) disable iff (rst)
    $fell(coproErrorIrq) |-> $past(sysResetReq || portReset))
    else $error("latched error fell without a reset");

  a_irq_rise_cause: assert property (@(posedge core_clk) disable iff (rst)
    $rose(coproErrorIrq) |-> $past(errSet))
    else $error("latched error rose without error and busy");

  a_irq_blocks_xfer: assert property (@(posedge core_clk) disable iff (rst)
    coproErrorIrq |-> !cpuXferReq)
    else $error("cpu request seen while error latched");

  a_sys_loads_count: assert property (@(posedge core_clk) disable iff (rst)
    sysResetReq |=> (resetCnt_reg == RESET_LOAD))
    else $error("system reset did not load the pulse counter");

  a_port_loads_count: assert property (@(posedge core_clk) disable iff (rst)
    (portReset && resetCnt_reg == RESET_CNT_INIT && !sysResetReq) |=>
      (resetCnt_reg == RESET_LOAD))
    else $error("port write did not load the pulse counter");

  a_count_steps_down: assert property (@(posedge core_clk) disable iff (rst)
    (resetCnt_reg != RESET_CNT_INIT && !sysResetReq) |=>
      (resetCnt_reg == $past(resetCnt_reg) - 8'h01))
    else $error("pulse counter did not step down");

  a_count_rests_idle: assert property (@(posedge core_clk) disable iff (rst)
    (resetCnt_reg == RESET_CNT_INIT && !sysResetReq && !portReset) |=>
      (resetCnt_reg == RESET_CNT_INIT))
    else $error("pulse counter left idle without a request");

  a_port_no_restart: assert property (@(posedge core_clk) disable iff (rst)
    (portReset && resetCnt_reg != RESET_CNT_INIT && !sysResetReq) |=>
      (resetCnt_reg == $past(resetCnt_reg) - 8'h01))
    else $error("port write stretched a running pulse");

  a_copro_tracks_count: assert property (@(posedge core_clk) disable iff (rst)
    coproResetOut == (resetCnt_reg != RESET_CNT_INIT))
    else $error("coprocessor reset out of step with counter");

  a_cpu_within_copro: assert property (@(posedge core_clk) disable iff (rst)
    cpuResetOut |-> coproResetOut)
    else $error("cpu reset without coprocessor reset");

  a_cpu_ends_together: assert property (@(posedge core_clk) disable iff (rst)
    (cpuResetOut && resetCnt_reg == 8'h01 && !sysResetReq) |=> !cpuResetOut)
    else $error("cpu reset outlived the pulse counter");

  a_port_holds_copro: assert property (@(posedge core_clk) disable iff (rst)
    (portReset && !coproResetOut && !sysResetReq) |=> coproResetOut [*8])
    else $error("port reset pulse ended early");

  a_port_spares_cpu: assert property (@(posedge core_clk) disable iff (rst)
    (coproResetOut && !cpuResetOut && !sysResetReq) |=> !cpuResetOut)
    else $error("cpu reset rose during a port pulse");

  a_idle_stays_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!coproResetOut && !sysResetReq && !portReset) |=> !coproResetOut)
    else $error("coprocessor reset rose without a request");

endmodule
`default_nettype wire

// >>> tb/ncif_copro_model.sv
`default_nettype none
module ncif_copro_model
  import ncif_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            opStart,
  input  wire logic [7:0]      opLen,
  input  wire logic            opErr,
  input  wire logic            opReq,
  output var  ncif_copro_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busyCnt = 8'h00;
  // non-blocking so the pins never move inside the edge that samples them
  always @(posedge core_clk) begin
    busyCnt <= opStart ? opLen : (busyCnt != 8'h00 ? busyCnt - 8'h01 : 8'h00);
  end
  // operand request only while an instruction runs; error is a plain level
  always_comb begin
    pins = '{busyN: (busyCnt == 8'h00), errorN: !opErr, xferReq: opReq && busyCnt != 8'h00};
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench
  import ncif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, sysResetReq, ioWrStb, portResetDisable, opStart, opErr, opReq;
  logic coproErrorIrq, cpuXferReq, coproResetOut, cpuResetOut;
  logic [IO_ADDR_W-1:0] ioAddr;
  logic [7:0]           opLen;
  ncif_copro_pins_t     pins;
  int errors = 0, check_count = 0, cp, cu, seed;
  ncif_copro_model model_u (.core_clk(core_clk), .opStart(opStart), .opLen(opLen),
    .opErr(opErr), .opReq(opReq), .pins(pins));
  ncif_core dut_u (.core_clk(core_clk), .rst(rst), .coproPins(pins),
    .sysResetReq(sysResetReq), .ioWrStb(ioWrStb), .ioAddr(ioAddr),
    .portResetDisable(portResetDisable), .coproErrorIrq(coproErrorIrq),
    .cpuXferReq(cpuXferReq), .coproResetOut(coproResetOut), .cpuResetOut(cpuResetOut));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // busy operation with a latched error; opLen random so the wait is prompt or slow
  task automatic set_err;
    opLen = 8'($urandom_range(20, 4)); opErr = 1'b1; opReq = 1'b1; opStart = 1'b1;
    cyc(1);
    opStart = 1'b0;
    cyc(5);
    `CHK(coproErrorIrq, 1'b1)
    `CHK(cpuXferReq, 1'b0)
    opErr = 1'b0;
    cyc(int'(opLen) + 4);
    `CHK(coproErrorIrq, 1'b1)
  endtask
  task automatic run_pulse(input logic sys, input logic [15:0] adr, input logic dis);
    sysResetReq = sys; ioWrStb = !sys; ioAddr = adr; portResetDisable = dis;
    cyc(1);
    sysResetReq = 1'b0; ioWrStb = 1'b0; cp = 0; cu = 0;
    repeat (40) begin
      cp += int'(coproResetOut); cu += int'(cpuResetOut);
      cyc(1);
    end
  endtask
  initial begin
    #40000;
    errors++;
    stop_test();
  end
  initial begin
    static logic sysT[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    static logic disT[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    static logic [15:0] adrT[4] =
      '{PORT_COPRO_RESET, PORT_COPRO_RESET, PORT_COPRO_RESET, 16'h00F0};
    logic acc;
    rst = 1'b1; sysResetReq = 1'b0; ioWrStb = 1'b0; ioAddr = 16'h0000;
    portResetDisable = 1'b0; opStart = 1'b0; opLen = 8'h00; opErr = 1'b0; opReq = 1'b0;
    seed = $urandom(79114);
    cyc(10);
    rst = 1'b0;
    cyc(2);
    for (int i = 0; i < 4; i++) begin
      set_err();
      acc = sysT[i] || (adrT[i] == PORT_COPRO_RESET && !disT[i]);
      run_pulse(sysT[i], adrT[i], disT[i]);
      `CHK(cp, acc ? int'(RESET_PULSE_CYC) : 0)
      `CHK(cu, sysT[i] ? int'(RESET_PULSE_CYC) : 0)
      `CHK(coproErrorIrq, !acc)
      // software init after the reset: a short busy op without error must not latch
      opLen = 8'h02; opStart = 1'b1;
      cyc(1);
      opStart = 1'b0;
      cyc(6);
      `CHK(coproErrorIrq, !acc)
    end
    $display("test reset paths done");
    run_pulse(1'b1, 16'h0000, 1'b0);
    `CHK(cu, int'(RESET_PULSE_CYC))
    `CHK(coproErrorIrq, 1'b0)
    // error level with busy released must not latch
    opErr = 1'b1;
    cyc(6);
    `CHK(coproErrorIrq, 1'b0)
    opErr = 1'b0;
    for (int i = 0; i < 8; i++) begin
      opReq = 1'($urandom); opLen = 8'h0A; opStart = 1'b1;
      cyc(1);
      opStart = 1'b0;
      cyc(4);
      `CHK(cpuXferReq, opReq)
      cyc(8);
      `CHK(cpuXferReq, 1'b0)
    end
    $display("test request path done");
    stop_test();
  end
endmodule
`default_nettype wire
